/* File: design/rst_src_pkg.sv */
// Purpose: Constants and types shared by the reset source logic.
// Assumes: One 10 MHz clock; all control bits are plain ports.
// Notes:   Boot option fields are captured once, when the power-on level is first seen good.
//
// Summary of operation
// - Low level on the external reset pin holds the device in reset.
// - Each of three supply monitors gives its own reset on supply fall.
// - Independent watchdog underflow or refresh error causes reset.
// - Second watchdog, when present, resets on underflow or refresh error.
// - Second watchdog reset sets a sticky detect flag for software.
// - One boot option bit selects second watchdog auto start.
// - Two-bit boot field selects second watchdog timeout period.
// - Four-bit boot field selects second watchdog clock division.
// - Two-bit boot field selects refresh window end position.
// - Two-bit boot field selects refresh window start position.
// - Boot option bit chooses reset or interrupt for second watchdog events.
// - Two-bit field in second option word selects fast oscillator frequency.
package rst_src_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned RST_HOLD_NS   = 1000;
  localparam int unsigned RST_HOLD_CYC  = (RST_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [15:0] SWRST_KEY     = 16'ha501;
  localparam logic [0:0]  WDOG2_PRESENT = 1'h1;
  // Bit positions in boot option word 0
  localparam int unsigned AUTOSTART_POS = 1;
  localparam int unsigned TIMEOUT_POS   = 2;
  localparam int unsigned CLKDIV_POS    = 4;
  localparam int unsigned WEND_POS      = 8;
  localparam int unsigned WSTART_POS    = 12;
  localparam int unsigned RSTIRQ_POS    = 28;
  // Bit position in boot option word 1
  localparam int unsigned FASTOSC_POS   = 12;
  // Reset values of captured options
  localparam logic [1:0]  TIMEOUT_RST   = 2'h3;
  localparam logic [3:0]  CLKDIV_RST    = 4'hf;
  localparam logic [1:0]  WIN_RST       = 2'h3;
  localparam logic [1:0]  FASTOSC_RST   = 2'h0;
  localparam int unsigned CNT_W         = 8;
  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_PIN, CAUSE_POR, CAUSE_MON, CAUSE_IWDG, CAUSE_WDOG2, CAUSE_SW
  } cause_t;
endpackage

/* File: design/rst_stretch.sv */
`timescale 1ns/10ps
// Purpose: Holds a reset request high for a minimum count after it drops.
// Assumes: Request is synchronous to ref_clk.
// Notes:   Output is registered.
module rst_stretch
  import rst_src_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic req,
  output logic      hold
);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             hold_q, hold_d;

  always_comb begin
    cnt_d  = cnt_q;
    hold_d = 1'b0;
    if (req) begin
      cnt_d  = CNT_W'(RST_HOLD_CYC);
      hold_d = 1'b1;
    end else if (cnt_q != '0) begin
      cnt_d  = cnt_q - 1'b1;
      hold_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= CNT_W'(RST_HOLD_CYC);
      hold_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_d;
      hold_q <= hold_d;
    end
  end

  assign hold = hold_q;
endmodule

/* File: design/reset_source_and_wdt_option_logic.sv */
`timescale 1ns/10ps
// Purpose: Combines reset sources and captures second watchdog boot options.
// Assumes: Analogue comparators deliver digital levels; pins are asynchronous.
// Notes:   wdog2_reset_flag survives the resets it reports; only rst_n or wdog2_flag_clr clears it.
module reset_source_and_wdt_option_logic
  import rst_src_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ext_reset_pin_n,
  input  wire logic        supply_above_por,
  input  wire logic [2:0]  supply_below_mon,
  input  wire logic [2:0]  mon_reset_en,
  input  wire logic        iwdg_underflow,
  input  wire logic        iwdg_refresh_err,
  input  wire logic        wdog2_underflow,
  input  wire logic        wdog2_refresh_err,
  input  wire logic [31:0] boot_option_word0,
  input  wire logic [31:0] boot_option_word1,
  input  wire logic        swrst_wr,
  input  wire logic [15:0] swrst_wdata,
  input  wire logic        wdog2_flag_clr,
  output logic             sys_reset,
  output logic [2:0]       mon_reset,
  output cause_t           last_cause,
  output logic             wdog2_reset_flag,
  output logic             wdog2_irq,
  output logic             wdog2_autostart_sel,
  output logic [1:0]       wdog2_timeout_sel,
  output logic [3:0]       wdog2_clkdiv_sel,
  output logic [1:0]       wdog2_window_end_sel,
  output logic [1:0]       wdog2_window_start_sel,
  output logic             wdog2_reset_or_irq_sel,
  output logic [1:0]       fast_osc_freq_sel
);
  // Two-flop synchronisers for asynchronous levels
  // Bit 0 pin low, bit 1 power-on good, bits 4:2 monitors below threshold
  logic [4:0] s1_q, s2_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
    end else begin
      s1_q <= {supply_below_mon, supply_above_por, ~ext_reset_pin_n};
      s2_q <= s1_q;
    end
  end
  logic       pin_low, por_ok;
  logic [2:0] mon_low;
  assign pin_low = s2_q[0];
  assign por_ok  = s2_q[1];
  assign mon_low = s2_q[4:2];

  // Option capture state
  logic       cap_q, cap_d;
  logic       auto_q, auto_d, rsel_q, rsel_d;
  logic [1:0] tops_q, tops_d, wend_q, wend_d, wst_q, wst_d, osc_q, osc_d;
  logic [3:0] cks_q, cks_d;

  always_comb begin
    cap_d  = cap_q;
    auto_d = auto_q;
    rsel_d = rsel_q;
    tops_d = tops_q;
    cks_d  = cks_q;
    wend_d = wend_q;
    wst_d  = wst_q;
    osc_d  = osc_q;
    if (!cap_q && por_ok) begin
      cap_d  = 1'b1;
      auto_d = boot_option_word0[AUTOSTART_POS];
      tops_d = boot_option_word0[TIMEOUT_POS +: 2];
      cks_d  = boot_option_word0[CLKDIV_POS +: 4];
      wend_d = boot_option_word0[WEND_POS +: 2];
      wst_d  = boot_option_word0[WSTART_POS +: 2];
      rsel_d = boot_option_word0[RSTIRQ_POS];
      osc_d  = boot_option_word1[FASTOSC_POS +: 2];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_q  <= 1'b0;
      auto_q <= 1'b0;
      rsel_q <= 1'b0;
      tops_q <= TIMEOUT_RST;
      cks_q  <= CLKDIV_RST;
      wend_q <= WIN_RST;
      wst_q  <= WIN_RST;
      osc_q  <= FASTOSC_RST;
    end else begin
      cap_q  <= cap_d;
      auto_q <= auto_d;
      rsel_q <= rsel_d;
      tops_q <= tops_d;
      cks_q  <= cks_d;
      wend_q <= wend_d;
      wst_q  <= wst_d;
      osc_q  <= osc_d;
    end
  end

  // Reset source combination
  logic       wd2_evt, wd2_rst, wd2_int, sw_req, iwdg_evt, req;
  logic [2:0] mon_evt;
  assign wd2_evt  = WDOG2_PRESENT[0] && cap_q && (wdog2_underflow || wdog2_refresh_err);
  assign wd2_rst  = wd2_evt && !rsel_q;
  assign wd2_int  = wd2_evt && rsel_q;
  assign sw_req   = swrst_wr && (swrst_wdata == SWRST_KEY);
  assign iwdg_evt = iwdg_underflow || iwdg_refresh_err;
  assign mon_evt  = mon_low & mon_reset_en;
  assign req      = pin_low || !por_ok || (|mon_evt) || iwdg_evt || wd2_rst || sw_req;

  logic hold;
  rst_stretch u_stretch (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .req     (req),
    .hold    (hold)
  );

  // Cause, flag and outputs
  cause_t     cause_q, cause_d;
  logic       flag_q, flag_d, irq_q, irq_d, sysr_q, sysr_d;
  logic [2:0] monr_q, monr_d;

  always_comb begin
    cause_d = cause_q;
    if (!por_ok)          cause_d = CAUSE_POR;
    else if (pin_low)     cause_d = CAUSE_PIN;
    else if (|mon_evt)    cause_d = CAUSE_MON;
    else if (iwdg_evt)    cause_d = CAUSE_IWDG;
    else if (wd2_rst)     cause_d = CAUSE_WDOG2;
    else if (sw_req)      cause_d = CAUSE_SW;
    flag_d = flag_q;
    // Set comes last so an event wins over a clear in the same cycle
    if (wdog2_flag_clr) flag_d = 1'b0;
    if (wd2_rst)        flag_d = 1'b1;
    irq_d  = wd2_int;
    sysr_d = hold || req;
    monr_d = mon_evt;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_q <= CAUSE_NONE;
      flag_q  <= 1'b0;
      irq_q   <= 1'b0;
      sysr_q  <= 1'b1;
      monr_q  <= 3'h0;
    end else begin
      cause_q <= cause_d;
      flag_q  <= flag_d;
      irq_q   <= irq_d;
      sysr_q  <= sysr_d;
      monr_q  <= monr_d;
    end
  end

  assign sys_reset              = sysr_q;
  assign mon_reset              = monr_q;
  assign last_cause             = cause_q;
  assign wdog2_reset_flag       = flag_q;
  assign wdog2_irq              = irq_q;
  assign wdog2_autostart_sel    = auto_q;
  assign wdog2_timeout_sel      = tops_q;
  assign wdog2_clkdiv_sel       = cks_q;
  assign wdog2_window_end_sel   = wend_q;
  assign wdog2_window_start_sel = wst_q;
  assign wdog2_reset_or_irq_sel = rsel_q;
  assign fast_osc_freq_sel      = osc_q;

  // Checks
  a_pin_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pin_low |=> sys_reset) else $error("pin low without reset");
  a_por_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !por_ok |=> sys_reset) else $error("reset released below power-on level");
  a_mon_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mon_evt[1] |=> mon_reset[1] && sys_reset) else $error("monitor 1 reset missing");
  // Per-monitor reset and its enable gate
  for (genvar m = 0; m < 3; m++) begin : g_mon
    a_mon_each: assert property (@(posedge ref_clk) disable iff (!rst_n)
      mon_evt[m] |=> mon_reset[m] && sys_reset) else $error("monitor reset missing");
    a_mon_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mon_low[m] && !mon_reset_en[m]) |=> !mon_reset[m]) else $error("disabled monitor reset");
  end
  a_iwdg_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    iwdg_refresh_err |=> sys_reset) else $error("watchdog reset missing");
  a_wd2_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wd2_rst |=> wdog2_reset_flag && sys_reset) else $error("wdog2 flag not set");
  a_wd2_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wd2_int && !hold && !pin_low && por_ok && !(|mon_evt) && !iwdg_evt && !sw_req)
    |=> wdog2_irq && !sys_reset) else $error("wdog2 irq path wrong");
  a_sw_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sw_req |=> sys_reset ##1 sys_reset) else $error("software reset too short");
  a_opt_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(cap_q) |-> $stable(wdog2_timeout_sel) && $stable(wdog2_clkdiv_sel))
    else $error("boot options changed after capture");
  a_opt_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!cap_q && por_ok) |=> wdog2_autostart_sel == $past(boot_option_word0[AUTOSTART_POS]))
    else $error("autostart not captured");
  // Guards on watchdog, software, hold and option capture paths
  a_iwdg_uf: assert property (@(posedge ref_clk) disable iff (!rst_n)
    iwdg_underflow |=> sys_reset) else $error("watchdog underflow reset missing");
  a_wd2_early: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!cap_q && !wdog2_reset_flag) |=> !wdog2_reset_flag && !wdog2_irq)
    else $error("wdog2 event taken before capture");
  a_flag_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wdog2_reset_flag && !wdog2_flag_clr) |=> wdog2_reset_flag) else $error("wdog2 flag lost");
  a_sw_key: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (swrst_wr && (swrst_wdata != SWRST_KEY) && !hold && !pin_low && por_ok && !(|mon_evt)
     && !iwdg_evt && !wd2_rst) |=> !sys_reset) else $error("wrong key caused reset");
  a_hold_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(req) |-> sys_reset [*8]) else $error("reset released too early");
  a_opt_window: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(cap_q) |-> $stable(wdog2_window_end_sel) && $stable(wdog2_window_start_sel))
    else $error("window options changed after capture");
  a_opt_misc: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(cap_q) |-> $stable(wdog2_autostart_sel) && $stable(wdog2_reset_or_irq_sel)
      && $stable(fast_osc_freq_sel)) else $error("start, select or oscillator option changed");
  c_pin: cover property (@(posedge ref_clk) disable iff (!rst_n) pin_low ##1 sys_reset);
  c_wd2_rst: cover property (@(posedge ref_clk) disable iff (!rst_n) wd2_rst);
  c_wd2_irq: cover property (@(posedge ref_clk) disable iff (!rst_n) wd2_int);
  c_release: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(sys_reset));
  c_sw: cover property (@(posedge ref_clk) disable iff (!rst_n) sw_req);
endmodule

/* File: dv/supply_partner.sv */
`timescale 1ns/10ps
// Purpose: Model of the reset pin and supply monitors outside the block.
// Assumes: Levels settle a short board delay after the bench commands them.
// Notes:   The pin is always driven, with no pull-up; it sits high whenever pin_low is clear.
module supply_partner (
  input  wire logic       pin_low,
  input  wire logic       por_ok,
  input  wire logic [2:0] mon_low,
  output logic            ext_reset_pin_n,
  output logic            supply_above_por,
  output logic [2:0]      supply_below_mon
);
  assign #7 ext_reset_pin_n  = !pin_low;
  assign #7 supply_above_por = por_ok;
  assign #7 supply_below_mon = mon_low;
endmodule

/* File: dv/test_reset_source_and_wdt_option_logic.sv */
`timescale 1ns/10ps
// Purpose: Self-checking bench for the reset source block.
// Assumes: Inputs change on the falling edge; sync events last one cycle.
// Notes:   Hold length is judged from the cycle the cause went away.
module test_reset_source_and_wdt_option_logic
  import rst_src_pkg::*;
;
  logic        ref_clk = 0, rst_n = 0, pin_low = 0, por_ok = 0;
  logic [2:0]  mon_low = 0, mon_en = 3'h7;
  logic        iw_uf = 0, iw_re = 0, w2_uf = 0, w2_re = 0, sw_wr = 0, fclr = 0;
  logic [15:0] sw_d = 16'h0;
  logic [31:0] w0 = 32'h0000_1266, w1 = 32'h0000_2000;
  logic        pin_n, por_up, sys, flag, irq, auto_s, rsel;
  logic [2:0]  mon_dn, mon_rst;
  logic [1:0]  tmo, wend, wst, osc;
  logic [3:0]  cdiv;
  cause_t      cause;
  int          n_fail = 0, checks = 0, cyc = 0;

  supply_partner far (.pin_low(pin_low), .por_ok(por_ok), .mon_low(mon_low),
    .ext_reset_pin_n(pin_n), .supply_above_por(por_up), .supply_below_mon(mon_dn));
  reset_source_and_wdt_option_logic uut (.ref_clk(ref_clk), .rst_n(rst_n),
    .ext_reset_pin_n(pin_n), .supply_above_por(por_up), .supply_below_mon(mon_dn),
    .mon_reset_en(mon_en), .iwdg_underflow(iw_uf), .iwdg_refresh_err(iw_re),
    .wdog2_underflow(w2_uf), .wdog2_refresh_err(w2_re), .boot_option_word0(w0),
    .boot_option_word1(w1), .swrst_wr(sw_wr), .swrst_wdata(sw_d),
    .wdog2_flag_clr(fclr), .sys_reset(sys), .mon_reset(mon_rst), .last_cause(cause),
    .wdog2_reset_flag(flag), .wdog2_irq(irq), .wdog2_autostart_sel(auto_s),
    .wdog2_timeout_sel(tmo), .wdog2_clkdiv_sel(cdiv), .wdog2_window_end_sel(wend),
    .wdog2_window_start_sel(wst), .wdog2_reset_or_irq_sel(rsel),
    .fast_osc_freq_sel(osc));

  always #50 ref_clk = ~ref_clk;

  task automatic stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Reset must linger for the hold count after its cause is gone
  task automatic released(input string nm);
    int n;
    n = 0;
    while (sys === 1'b1 && n < 80) begin
      cyc_n(1);
      n++;
    end
    chk(nm, (n >= RST_HOLD_CYC + 2 && n <= RST_HOLD_CYC + 4), 1);
  endtask

  task automatic t_boot;
    chk("rst_tmo", tmo, TIMEOUT_RST);
    chk("rst_cdiv", cdiv, CLKDIV_RST);
    chk("rst_win", {wend, wst}, {WIN_RST, WIN_RST});
    chk("rst_osc", osc, FASTOSC_RST);
    cyc_n(30);
    chk("por_hold", sys, 1);
    por_ok = 1;
    released("por_rel");
    chk("auto", auto_s, w0[AUTOSTART_POS]);
    chk("tmo", tmo, w0[TIMEOUT_POS+:2]);
    chk("cdiv", cdiv, w0[CLKDIV_POS+:4]);
    chk("wend", wend, w0[WEND_POS+:2]);
    chk("wst", wst, w0[WSTART_POS+:2]);
    chk("rsel", rsel, w0[RSTIRQ_POS]);
    chk("osc", osc, w1[FASTOSC_POS+:2]);
  endtask

  task automatic t_pin;
    pin_low = 1;
    cyc_n(4);
    chk("pin_cause", {sys, cause}, {1'b1, CAUSE_PIN});
    cyc_n(20);
    chk("pin_held", sys, 1);
    pin_low = 0;
    released("pin_rel");
  endtask

  task automatic t_mon;
    for (int i = 0; i < 3; i++) begin
      mon_low = 3'h1 << i;
      cyc_n(5);
      chk("mon_rst", {sys, mon_rst, cause}, {1'b1, 3'h1 << i, CAUSE_MON});
      mon_low = 0;
      released("mon_rel");
    end
    mon_en = 3'h0;
    mon_low = 3'h7;
    cyc_n(5);
    chk("mon_off", {sys, mon_rst}, 4'h0);
    mon_low = 0;
    // Let the synchronised level clear before enabling again
    cyc_n(3);
    mon_en = 3'h7;
  endtask

  task automatic t_wdog;
    for (int k = 0; k < 4; k++) begin
      // Last pass raises the clear with the event: the set must win
      {w2_re, w2_uf, iw_re, iw_uf} = 4'h1 << k;
      fclr = (k == 3);
      cyc_n(1);
      {w2_re, w2_uf, iw_re, iw_uf} = 4'h0;
      fclr = 0;
      chk("wd_cause", {sys, cause}, {1'b1, (k < 2) ? CAUSE_IWDG : CAUSE_WDOG2});
      chk("wd_flag", {flag, irq}, {k > 1, 1'b0});
      released("wd_rel");
      chk("flag_keep", flag, k > 1);
      fclr = 1;
      cyc_n(1);
      fclr = 0;
      cyc_n(1);
      chk("flag_clr", flag, 0);
    end
  endtask

  task automatic t_sw;
    sw_d = SWRST_KEY ^ 16'h0001;
    sw_wr = 1;
    cyc_n(1);
    sw_wr = 0;
    cyc_n(2);
    chk("sw_bad", sys, 0);
    sw_d = SWRST_KEY;
    sw_wr = 1;
    cyc_n(1);
    sw_wr = 0;
    chk("sw_cause", {sys, cause}, {1'b1, CAUSE_SW});
    released("sw_rel");
  endtask

  task automatic t_irq;
    w0[RSTIRQ_POS] = 1'b1;
    rst_n = 0;
    cyc_n(6);
    rst_n = 1;
    w2_uf = 1;
    cyc_n(1);
    w2_uf = 0;
    released("irq_boot");
    chk("early_wd2", {flag, irq}, 2'h0);
    chk("irq_sel", rsel, 1);
    w2_uf = 1;
    cyc_n(1);
    w2_uf = 0;
    chk("irq_ev", {irq, sys, flag}, 3'h4);
  endtask

  initial begin
    cyc_n(6);
    rst_n = 1;
    t_boot();
    t_pin();
    t_mon();
    t_wdog();
    t_sw();
    t_irq();
    stop_test();
  end
endmodule
